// [qrlpe_pkg.sv]
package qrlpe_pkg;
  localparam logic [7:0] OPC_WREN     = 8'h06;
  localparam logic [7:0] OPC_ASI      = 8'h25;
  localparam logic [7:0] OPC_PE_A     = 8'h81;
  localparam logic [7:0] OPC_PE_B     = 8'hDB;
  localparam logic [7:0] OPC_QRD      = 8'hEB;
  localparam logic [7:0] OPC_QRD_DW   = 8'hE7;
  localparam int         SR5_LAT_LSB  = 4;
  localparam int         SR5_LAT_MSB  = 6;
  localparam int         SR5_DWA_BIT  = 0;
  localparam int         SR1_BUSY_BIT = 0;
  localparam int         SR1_WEL_BIT  = 1;
  localparam int         SR4_EE_BIT   = 2;
  localparam int         SR4_PE_BIT   = 3;
  localparam int         PAGE_LSB     = 8;
  localparam int         PAGE_MSB     = 20;
  localparam int         PAGE_W       = 13;
  localparam logic [2:0] LAT_SEL_LAST = 3'h4;
  localparam logic [3:0] DUMMY_STEP   = 4'h2;
  localparam logic [3:0] DUMMY_MAX    = 4'hA;
  localparam logic [1:0] ADDR_BYTES   = 2'h3;
  localparam logic [2:0] BIT_LAST     = 3'h7;
  localparam logic [2:0] QADDR_LAST   = 3'h5;
  localparam logic [2:0] QMODE_LAST   = 3'h1;
  localparam int         MODE_CONT_LSB = 4;
  localparam logic [1:0] MODE_CONT_VAL = 2'h2;
  localparam int         CLK_MHZ      = 250;
  localparam int         PAGE_ERASE_TIME_US = 25000;

  typedef enum logic [2:0] {
    QRLPE_IDLE, QRLPE_OPC, QRLPE_ADDR, QRLPE_QADDR,
    QRLPE_QMODE, QRLPE_ASI, QRLPE_SKIP
  } qrlpe_phase_t;

  typedef struct packed {
    logic       cs_n;
    logic       sck;
    logic [3:0] io;
  } qrlpe_pins_t;

  typedef struct packed {
    logic       done;
    logic       fail;
  } qrlpe_array_t;
endpackage

// [qrlpe_core.sv]
`timescale 1ns/1ps
module qrlpe_core import qrlpe_pkg::*; #(
  parameter int PE_TIME_US = PAGE_ERASE_TIME_US
) (
  // Clock and reset
  input  wire logic                clk_in,
  input  wire logic                sys_rst_in,
  // Host pins
  input  wire qrlpe_pins_t         pins_in,
  output logic                     so_out,
  output logic                     so_oe_out,
  // Configuration
  input  wire logic [7:0]          status_register_five_in,
  input  wire logic                protect_in,
  // Flash array
  input  wire qrlpe_array_t        array_in,
  output logic                     erase_start_out,
  output logic [PAGE_W-1:0]        page_index_out,
  // Status and latency
  output logic [7:0]               status_register_one_out,
  output logic [7:0]               status_register_four_out,
  output logic [3:0]               dummy_clocks_out,
  output logic                     read_dword_out,
  output logic                     cont_read_out
);
  localparam int PE_CYCLES = PE_TIME_US * CLK_MHZ;
  localparam int TIMER_W   = $clog2(PE_CYCLES + 1);

  if (PE_TIME_US < 1) begin : g_chk
    $error("erase time must be at least one microsecond");
  end

  typedef struct packed {
    qrlpe_pins_t          s1;
    qrlpe_pins_t          s2;
    qrlpe_pins_t          s3;
    qrlpe_pins_t          pin;
    qrlpe_phase_t         phase;
    logic [2:0]           bit_cnt;
    logic [1:0]           byte_cnt;
    logic [23:0]          shift;
    logic [7:0]           opc;
    logic [7:0]           mode;
    logic                 dw_cmd;
    logic                 cont;
    logic                 write_enable_latch;
    logic                 busy;
    logic                 ee;
    logic                 pe;
    logic [TIMER_W-1:0]   timer;
    logic                 start;
    logic [PAGE_W-1:0]    page;
    logic                 so;
    logic                 so_oe;
    logic [3:0]           dummy;
    logic                 dword;
  } qrlpe_state_t;

  qrlpe_state_t state_reg;
  qrlpe_state_t state_next;

  function automatic logic [3:0] dummy_of(input logic [2:0] sel);
    logic [2:0] s;
    s = sel;
    if (s > LAT_SEL_LAST) begin
      s = LAT_SEL_LAST;
    end
    return DUMMY_STEP * ({1'b0, s} + 4'h1);
  endfunction

  always_comb begin
    logic       cs_fall;
    logic       cs_rise;
    logic       sck_rise;
    logic       si;
    logic [7:0] opc_now;
    logic [7:0] mode_now;
    cs_fall  = 1'b0;
    cs_rise  = 1'b0;
    sck_rise = 1'b0;
    si       = 1'b0;
    opc_now  = 8'h00;
    mode_now = 8'h00;
    state_next = state_reg;
    state_next.start = 1'b0;

    // Three-stage pin sampling, change taken when stages two and three agree
    state_next.s1 = pins_in;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    if (state_reg.s2.cs_n == state_reg.s3.cs_n) begin
      state_next.pin.cs_n = state_reg.s2.cs_n;
    end
    if (state_reg.s2.sck == state_reg.s3.sck) begin
      state_next.pin.sck = state_reg.s2.sck;
    end
    for (int i = 0; i < 4; i++) begin
      if (state_reg.s2.io[i] == state_reg.s3.io[i]) begin
        state_next.pin.io[i] = state_reg.s2.io[i];
      end
    end

    cs_fall  = state_reg.pin.cs_n & ~state_next.pin.cs_n;
    cs_rise  = ~state_reg.pin.cs_n & state_next.pin.cs_n;
    sck_rise = ~state_reg.pin.sck & state_next.pin.sck
             & ~state_next.pin.cs_n;
    si       = state_next.pin.io[0];
    opc_now  = {state_reg.shift[6:0], si};
    mode_now = {state_reg.mode[3:0], state_next.pin.io};

    // Self-timed erase run
    if (state_reg.busy) begin
      if (array_in.done) begin
        state_next.busy = 1'b0;
        state_next.ee   = array_in.fail;
        state_next.pe   = array_in.fail;
      end else if (state_reg.timer == '0) begin
        state_next.busy = 1'b0;
        state_next.ee   = 1'b1;
        state_next.pe   = 1'b1;
      end else begin
        state_next.timer = state_reg.timer - 1'b1;
      end
    end

    if (cs_fall) begin
      state_next.phase    = state_reg.cont ? QRLPE_QADDR : QRLPE_OPC;
      state_next.bit_cnt  = 3'h0;
      state_next.byte_cnt = 2'h0;
    end else if (cs_rise) begin
      if (state_reg.phase == QRLPE_ADDR
          && state_reg.bit_cnt == 3'h0
          && state_reg.byte_cnt == ADDR_BYTES
          && state_reg.write_enable_latch
          && !state_reg.busy
          && !protect_in) begin
        state_next.start = 1'b1;
        state_next.busy  = 1'b1;
        state_next.write_enable_latch   = 1'b0;
        state_next.ee    = 1'b0;
        state_next.pe    = 1'b0;
        state_next.timer = TIMER_W'(PE_CYCLES);
        state_next.page  = state_reg.shift[PAGE_MSB:PAGE_LSB];
      end else if (state_reg.phase == QRLPE_SKIP
                   && state_reg.opc == OPC_WREN
                   && state_reg.bit_cnt == 3'h0
                   && !state_reg.busy) begin
        state_next.write_enable_latch = 1'b1;
      end
      state_next.phase = QRLPE_IDLE;
    end else if (sck_rise) begin
      state_next.bit_cnt = state_reg.bit_cnt + 3'h1;
      case (state_reg.phase)
        QRLPE_OPC: begin
          state_next.shift = {state_reg.shift[22:0], si};
          if (state_reg.bit_cnt == BIT_LAST) begin
            state_next.opc   = opc_now;
            state_next.phase = QRLPE_SKIP;
            if ((opc_now == OPC_PE_A || opc_now == OPC_PE_B)
                && !state_reg.busy) begin
              state_next.phase    = QRLPE_ADDR;
              state_next.byte_cnt = 2'h0;
            end else if ((opc_now == OPC_QRD || opc_now == OPC_QRD_DW)
                         && !state_reg.busy) begin
              state_next.phase   = QRLPE_QADDR;
              state_next.dw_cmd  = (opc_now == OPC_QRD_DW);
              state_next.bit_cnt = 3'h0;
            end else if (opc_now == OPC_ASI) begin
              state_next.phase = QRLPE_ASI;
            end
          end
        end
        QRLPE_ADDR: begin
          state_next.shift = {state_reg.shift[22:0], si};
          if (state_reg.bit_cnt == BIT_LAST
              && state_reg.byte_cnt != ADDR_BYTES) begin
            state_next.byte_cnt = state_reg.byte_cnt + 2'h1;
          end
        end
        QRLPE_QADDR: begin
          state_next.shift = {state_reg.shift[19:0], state_next.pin.io};
          if (state_reg.bit_cnt == QADDR_LAST) begin
            state_next.phase   = QRLPE_QMODE;
            state_next.bit_cnt = 3'h0;
          end
        end
        QRLPE_QMODE: begin
          state_next.mode = mode_now;
          if (state_reg.bit_cnt == QMODE_LAST) begin
            state_next.cont = (mode_now[MODE_CONT_LSB +: 2]
                               == MODE_CONT_VAL);
            state_next.phase = QRLPE_SKIP;
          end
        end
        default: begin
        end
      endcase
    end

    // Active status interrupt drives busy each cycle
    state_next.so_oe = (state_next.phase == QRLPE_ASI);
    state_next.so    = state_next.busy;

    // Quad-read latency selection
    state_next.dummy = dummy_of(
      status_register_five_in[SR5_LAT_MSB:SR5_LAT_LSB]);
    state_next.dword = state_next.dw_cmd
                     | status_register_five_in[SR5_DWA_BIT];
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  always_comb begin
    status_register_one_out = 8'h00;
    status_register_one_out[SR1_BUSY_BIT] = state_reg.busy;
    status_register_one_out[SR1_WEL_BIT]  = state_reg.write_enable_latch;
    status_register_four_out = 8'h00;
    status_register_four_out[SR4_EE_BIT] = state_reg.ee;
    status_register_four_out[SR4_PE_BIT] = state_reg.pe;
  end

  assign so_out           = state_reg.so;
  assign so_oe_out        = state_reg.so_oe;
  assign erase_start_out  = state_reg.start;
  assign page_index_out   = state_reg.page;
  assign dummy_clocks_out = state_reg.dummy;
  assign read_dword_out   = state_reg.dword;
  assign cont_read_out    = state_reg.cont;
endmodule

// [qrlpe_core_props.sv]
`timescale 1ns/1ps
module qrlpe_core_props import qrlpe_pkg::*; #(
  parameter int PE_TIME_US = PAGE_ERASE_TIME_US
) (
  // Clock and reset
  input wire logic              clk_in,
  input wire logic              sys_rst_in,
  // Watched ports
  input wire logic              so_out,
  input wire logic              so_oe_out,
  input wire logic [7:0]        status_register_five_in,
  input wire logic              protect_in,
  input wire logic              erase_start_out,
  input wire logic [PAGE_W-1:0] page_index_out,
  input wire logic [7:0]        status_register_one_out,
  input wire logic [7:0]        status_register_four_out,
  input wire logic [3:0]        dummy_clocks_out
);
  localparam int BUSY_MAX = PE_TIME_US * CLK_MHZ + 16;
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  int busy_cnt;
  always_ff @(posedge clk_in)
    busy_cnt <= (sys_rst_in || !status_register_one_out[0]) ? 0 : busy_cnt + 1;
  sequence s_busy_run;
    (status_register_one_out[1:0] == 2'h1) [*4];
  endsequence
  a_dummy_map: assert property (!$past(sys_rst_in) |-> dummy_clocks_out ==
    (($past(status_register_five_in[6:4]) > 3'h4) ? 4'hA :
    {$past(status_register_five_in[6:4]), 1'b0} + 4'h2))
    else $error("dummy count mismatch");
  a_start_gated: assert property (erase_start_out |->
    $past(status_register_one_out[1]) && !$past(status_register_one_out[0]))
    else $error("erase started without latch or while busy");
  a_start_protect: assert property (erase_start_out |-> !$past(protect_in))
    else $error("erase started on protected memory");
  a_busy_run: assert property (erase_start_out |-> s_busy_run)
    else $error("busy or latch wrong after start");
  a_busy_bound: assert property (busy_cnt <= BUSY_MAX)
    else $error("erase never finished");
  a_so_busy: assert property (so_oe_out && $stable(status_register_one_out[0])
    |-> so_out == status_register_one_out[0]) else $error("serial busy wrong");
  a_fail_pair: assert property (
    status_register_four_out[2] == status_register_four_out[3])
    else $error("fail flags disagree");
  a_page_hold: assert property (!erase_start_out |-> $stable(page_index_out))
    else $error("page index moved without start");
endmodule
bind qrlpe_core qrlpe_core_props #(.PE_TIME_US(PE_TIME_US)) i_qrlpe_core_props (.*);

// [qrlpe_array_model.sv]
`timescale 1ns/1ps
module qrlpe_array_model import qrlpe_pkg::*; (
  // Clock, start from the sequencer, delay and fail from the bench
  input  wire logic       clk_in,
  input  wire logic       start_in,
  input  wire logic [9:0] delay_in,
  input  wire logic       fail_in,
  // Completion to the sequencer
  output qrlpe_array_t    array_out
);
  logic [9:0] cnt_reg = 10'h000;
  logic       run_reg = 1'b0;
  logic       hit;
  // Zero delay never answers
  assign hit = run_reg && cnt_reg == delay_in && delay_in != 10'h000;
  // Fail only valid with done
  assign array_out = '{hit, hit ? fail_in : cnt_reg[0]};
  always_ff @(posedge clk_in) begin
    cnt_reg <= start_in ? 10'h001 : cnt_reg + 10'h001;
    run_reg <= start_in || (run_reg && !hit);
  end
endmodule

// [qrlpe_core_tb_top.sv]
`timescale 1ns/1ps
module qrlpe_core_tb_top import qrlpe_pkg::*;;
  localparam logic [3:0] DC_EXP [8] = '{4'h2, 4'h4, 4'h6, 4'h8,
                                        4'hA, 4'hA, 4'hA, 4'hA};
  logic         clk_in = 1'b0, sys_rst_in = 1'b1, protect_in = 1'b0;
  logic         fail_in = 1'b0, so_out, so_oe_out, erase_start_out;
  logic         read_dword_out, cont_read_out;
  logic [7:0]   sr5 = 8'h00, sr1, sr4;
  logic [3:0]   dc;
  logic [12:0]  page;
  logic [9:0]   delay_in = 10'h00A;
  qrlpe_pins_t  pins = '{1'b1, 1'b0, 4'h0};
  qrlpe_array_t arr;
  int           n_fail = 0, compares = 0, n_start = 0, cyc = 0;
  qrlpe_core #(.PE_TIME_US(2)) i_qrlpe_core (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .pins_in(pins), .so_out(so_out),
    .so_oe_out(so_oe_out), .status_register_five_in(sr5),
    .protect_in(protect_in), .array_in(arr),
    .erase_start_out(erase_start_out), .page_index_out(page),
    .status_register_one_out(sr1), .status_register_four_out(sr4),
    .dummy_clocks_out(dc), .read_dword_out(read_dword_out),
    .cont_read_out(cont_read_out));
  qrlpe_array_model i_qrlpe_array_model (.clk_in(clk_in),
    .start_in(erase_start_out), .delay_in(delay_in), .fail_in(fail_in),
    .array_out(arr));
  initial forever #2 clk_in = ~clk_in;
  task automatic finish_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    n_start += erase_start_out;
    if (cyc == 30000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [15:0] exp, got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  // SCK near 8 MHz, far below any limit
  task automatic xfer(input logic [63:0] v, input int ns, nq);
    for (int i = 0; i < ns + nq; i++) begin
      @(negedge clk_in);
      pins.cs_n = 1'b0;
      pins.sck = 1'b0;
      pins.io = (i < ns) ? {v[62:60], v[63]} : v[63:60];
      v = (i < ns) ? v << 1 : v << 4;
      repeat (15) @(negedge clk_in);
      pins.sck = 1'b1;
      repeat (16) @(negedge clk_in);
    end
  endtask
  task automatic cs_up();
    @(negedge clk_in);
    pins.sck = 1'b0;
    repeat (16) @(negedge clk_in);
    pins.cs_n = 1'b1;
    pins.io = ~pins.io;
    repeat (12) @(negedge clk_in);
  endtask
  task automatic frame(input logic [63:0] v, input int ns);
    xfer(v, ns, 0);
    cs_up();
  endtask
  initial begin
    repeat (5) @(negedge clk_in);
    sys_rst_in = 1'b0;
    repeat (8) @(negedge clk_in);
    chk("sr1_rst", 16'h0, sr1);
    for (int i = 0; i < 8; i++) begin
      sr5 = {1'b0, i[2:0], 3'h0, i[0]};
      repeat (2) @(negedge clk_in);
      chk("dummy", DC_EXP[i], dc);
      chk("dword", i[0], read_dword_out);
    end
    frame({8'h81, 24'h001200, 32'h0}, 32);
    chk("no_wel", 16'h0, n_start);
    delay_in = 10'h190;
    frame({8'h06, 56'h0}, 8);
    chk("wel", 16'h2, sr1);
    frame({8'h81, 24'hFFABCD, 32'h0}, 32);
    chk("start", 16'h1, n_start);
    chk("page", 16'h1FAB, page);
    chk("sr1_busy", 16'h1, sr1);
    xfer({8'h25, 56'h0}, 8, 0);
    repeat (4) @(negedge clk_in);
    chk("so_busy", 16'h3, {so_oe_out, so_out});
    for (int k = 0; k < 400 && so_out; k++) @(negedge clk_in);
    chk("so_done", 16'h2, {so_oe_out, so_out});
    cs_up();
    chk("so_off", 16'h0, {sr4, so_oe_out});
    delay_in = 10'h00A;
    fail_in = 1'b1;
    frame({8'h06, 56'h0}, 8);
    frame({8'hDB, 56'h0}, 31);
    frame({8'hDB, 56'h0}, 16);
    protect_in = 1'b1;
    frame({8'hDB, 56'h0}, 32);
    chk("aborts", 16'h1, n_start);
    protect_in = 1'b0;
    frame({8'hDB, 24'h000100, 32'h0}, 32);
    chk("page_db", 16'h1, page);
    repeat (40) @(negedge clk_in);
    chk("sr4_fail", 16'h0C, sr4);
    chk("sr1_idle", 16'h0, sr1);
    sr5 = 8'h00;
    xfer({8'hE7, 24'h000100, 8'h20, 24'h0}, 8, 8);
    cs_up();
    chk("e7", 16'h3, {read_dword_out, cont_read_out});
    xfer({24'h000100, 8'h00, 32'h0}, 0, 8);
    cs_up();
    chk("cont_off", 16'h0, cont_read_out);
    xfer({8'hEB, 24'h000100, 8'h00, 24'h0}, 8, 8);
    cs_up();
    chk("eb", 16'h0, {read_dword_out, cont_read_out});
    finish_test();
  end
endmodule
